// ==== rtl/pfcpwm_pkg.sv ====
package pfcpwm_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int CNT_W = 16;
    localparam int PRE_W = 10;
    localparam int NCH = 2;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_COUNT = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_CMPA = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_CMPB = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_TOP = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_FLAGS = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h18;

    // Control register layout
    localparam int CTRL_W = 16;
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_CS_LSB = 4;
    localparam int CTRL_COM_LSB = 8;
    localparam int CTRL_DIR_LSB = 12;
    localparam int CTRL_PEN_LSB = 14;
    localparam logic [CTRL_W-1:0] CTRL_RST = 16'h0000;

    // Flag register layout
    localparam int FLG_W = 4;
    localparam int FLG_OVF = 0;
    localparam int FLG_CAP = 1;
    localparam int FLG_CMP_LSB = 2;

    localparam int STS_DOWN = 0;
    localparam int STS_LVL_LSB = 1;

    localparam logic [3:0] MODE_CAPTOP = 4'h8;
    localparam logic [3:0] MODE_CMPTOP = 4'h9;
    localparam int MODE_TOPBIT = 3;

    localparam logic [1:0] COM_OFF = 2'h0;
    localparam logic [1:0] COM_TOGGLE = 2'h1;
    localparam logic [1:0] COM_NONINV = 2'h2;
    localparam logic [1:0] COM_INV = 2'h3;

    localparam logic [2:0] CS_STOP = 3'h0;
    localparam logic [2:0] CS_DIV1 = 3'h1;
    localparam logic [2:0] CS_DIV8 = 3'h2;
    localparam logic [2:0] CS_DIV64 = 3'h3;
    localparam logic [2:0] CS_DIV256 = 3'h4;
    localparam logic [2:0] CS_DIV1024 = 3'h5;
    localparam logic [PRE_W-1:0] MASK_DIV1 = 10'h000;
    localparam logic [PRE_W-1:0] MASK_DIV8 = 10'h007;
    localparam logic [PRE_W-1:0] MASK_DIV64 = 10'h03f;
    localparam logic [PRE_W-1:0] MASK_DIV256 = 10'h0ff;
    localparam logic [PRE_W-1:0] MASK_DIV1024 = 10'h3ff;

    localparam logic [CNT_W-1:0] CNT_BOTTOM = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic {DIR_UP, DIR_DOWN} pfcpwm_dir_t;
endpackage

// ==== rtl/pfcpwm_presc.sv ====
`timescale 1ns/1ps
module pfcpwm_presc
    import pfcpwm_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Select and tick
    input wire logic [2:0] clk_sel,
    output logic tick
);
    logic [PRE_W-1:0] cnt;
    logic [PRE_W-1:0] next_cnt;
    logic [PRE_W-1:0] mask;
    logic next_tick;

    always_comb begin
        case (clk_sel)
            CS_DIV1: mask = MASK_DIV1;
            CS_DIV8: mask = MASK_DIV8;
            CS_DIV64: mask = MASK_DIV64;
            CS_DIV256: mask = MASK_DIV256;
            CS_DIV1024: mask = MASK_DIV1024;
            default: mask = MASK_DIV1;
        endcase
        // Stopped or unused codes give no tick at all
        if (clk_sel == CS_STOP || clk_sel > CS_DIV1024) begin
            next_cnt = '0;
            next_tick = 1'b0;
        end else begin
            next_cnt = cnt + 1'b1;
            next_tick = ((cnt & mask) == mask);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt <= '0;
            tick <= 1'b0;
        end else begin
            cnt <= next_cnt;
            tick <= next_tick;
        end
    end
endmodule

// ==== rtl/pfcpwm_chan.sv ====
`timescale 1ns/1ps
module pfcpwm_chan
    import pfcpwm_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Compare event
    input wire logic match,
    input wire logic eff_down,
    // Configuration
    input wire logic [1:0] act_sel,
    input wire logic toggle_ok,
    // Waveform level
    output logic level
);
    logic next_level;

    always_comb begin
        next_level = level;
        if (match) begin
            case (act_sel)
                COM_NONINV: next_level = eff_down;
                COM_INV: next_level = !eff_down;
                COM_TOGGLE: begin
                    if (toggle_ok) begin
                        next_level = !level;
                    end
                end
                default: next_level = level;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            level <= 1'b0;
        end else begin
            level <= next_level;
        end
    end
endmodule

// ==== rtl/pfcpwm_top.sv ====
// The AXI4-Lite register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module pfcpwm_top
    import pfcpwm_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address
    input wire logic awvalid,
    output logic awready,
    input wire logic [pfcpwm_pkg::ADDR_W-1:0] awaddr,
    input wire logic [2:0] awprot,
    // AXI4-Lite write data
    input wire logic wvalid,
    output logic wready,
    input wire logic [pfcpwm_pkg::DATA_W-1:0] wdata,
    input wire logic [3:0] wstrb,
    // AXI4-Lite write response
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // AXI4-Lite read address
    input wire logic arvalid,
    output logic arready,
    input wire logic [pfcpwm_pkg::ADDR_W-1:0] araddr,
    input wire logic [2:0] arprot,
    // AXI4-Lite read data
    output logic rvalid,
    input wire logic rready,
    output logic [pfcpwm_pkg::DATA_W-1:0] rdata,
    output logic [1:0] rresp,
    // Compare output pins
    output logic out_a,
    output logic oe_a,
    output logic out_b,
    output logic oe_b
);
    import pfcpwm_pkg::*;

    logic aw_held, w_held, next_aw_held, next_w_held;
    logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
    logic [1:0] next_bresp, next_rresp;
    logic [DATA_W-1:0] next_rdata;
    logic [ADDR_W-1:0] wr_addr, next_wr_addr;
    logic [DATA_W-1:0] wr_data, next_wr_data;
    logic [3:0] wr_strb, next_wr_strb;
    logic [CTRL_W-1:0] ctrl, next_ctrl;
    logic [CNT_W-1:0] buf_q [NCH];
    logic [CNT_W-1:0] next_buf [NCH];
    logic [CNT_W-1:0] top_cap, next_top_cap;
    logic [FLG_W-1:0] flags, next_flags, flag_set, flag_clr;

    logic [CNT_W-1:0] cnt, next_cnt, top;
    logic [CNT_W-1:0] ocr [NCH];
    logic [CNT_W-1:0] next_ocr [NCH];
    pfcpwm_dir_t dir, next_dir;
    logic tick, run, at_top, at_bottom, eff_down, ev_ovf, ev_top;
    logic [NCH-1:0] match, level, drive, next_oe;
    logic [3:0] mode;
    logic [2:0] clk_sel;
    logic [2*NCH-1:0] com;
    logic [NCH-1:0] pin_dir, pin_en;

    assign mode = ctrl[CTRL_MODE_LSB +: 4];
    assign clk_sel = ctrl[CTRL_CS_LSB +: 3];
    assign com = ctrl[CTRL_COM_LSB +: 2*NCH];
    assign pin_dir = ctrl[CTRL_DIR_LSB +: NCH];
    assign pin_en = ctrl[CTRL_PEN_LSB +: NCH];

    function automatic logic [CNT_W-1:0] merge16(
        input logic [CNT_W-1:0] old,
        input logic [DATA_W-1:0] data,
        input logic [3:0] strb
    );
        logic [CNT_W-1:0] res;
        res = old;
        if (strb[0]) begin
            res[7:0] = data[7:0];
        end
        if (strb[1]) begin
            res[15:8] = data[15:8];
        end
        return res;
    endfunction

    // Timer tick source, used purely as an enable
    pfcpwm_presc u_presc (
        .aclk(aclk),
        .aresetn(aresetn),
        .clk_sel(clk_sel),
        .tick(tick)
    );

    // Counter, direction and double-buffered compare values
    always_comb begin
        run = (mode == MODE_CAPTOP) || (mode == MODE_CMPTOP);
        top = (mode == MODE_CMPTOP) ? ocr[0] : top_cap;
        at_bottom = (cnt == CNT_BOTTOM);
        // A lowered TOP below the count still turns the counter round
        at_top = (cnt >= top);
        // Matches at the turning points take the slope that follows them
        if (at_top) begin
            eff_down = 1'b1;
        end else if (at_bottom) begin
            eff_down = 1'b0;
        end else begin
            eff_down = (dir == DIR_DOWN);
        end
        next_cnt = cnt;
        next_dir = dir;
        next_ocr = ocr;
        if (!run) begin
            // Idle: parked at BOTTOM, buffers pass straight through
            next_cnt = CNT_BOTTOM;
            next_dir = DIR_UP;
            next_ocr = buf_q;
        end else if (tick) begin
            if (at_bottom) begin
                next_ocr = buf_q;
            end
            if (dir == DIR_UP) begin
                if (at_top) begin
                    next_dir = DIR_DOWN;
                    next_cnt = cnt - CNT_ONE;
                end else begin
                    next_cnt = cnt + CNT_ONE;
                end
            end else begin
                if (at_bottom) begin
                    next_dir = DIR_UP;
                    next_cnt = cnt + CNT_ONE;
                end else begin
                    next_cnt = cnt - CNT_ONE;
                end
            end
        end
        ev_ovf = run && tick && at_bottom;
        ev_top = run && tick && at_top;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt <= CNT_BOTTOM;
            dir <= DIR_UP;
            ocr <= '{default: CNT_BOTTOM};
        end else begin
            cnt <= next_cnt;
            dir <= next_dir;
            ocr <= next_ocr;
        end
    end

    // Per-channel compare and waveform
    genvar ch;
    generate
        for (ch = 0; ch < NCH; ch++) begin : g_ch
            assign match[ch] = run && tick && (cnt == ocr[ch]);
            // Only channel A may toggle; B leaves it reserved and idle
            pfcpwm_chan u_chan (
                .aclk(aclk),
                .aresetn(aresetn),
                .match(match[ch]),
                .eff_down(eff_down),
                .act_sel(com[2*ch +: 2]),
                .toggle_ok((ch == 0) && mode[MODE_TOPBIT]),
                .level(level[ch])
            );
            // Any action but off, toggle on B, or toggle without top bit
            assign drive[ch] = (com[2*ch +: 2] == COM_NONINV) ||
                (com[2*ch +: 2] == COM_INV) ||
                ((com[2*ch +: 2] == COM_TOGGLE) && (ch == 0) &&
                 mode[MODE_TOPBIT]);
            assign next_oe[ch] = drive[ch] && pin_dir[ch] &&
                pin_en[ch];
        end
    endgenerate

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            out_a <= 1'b0;
            out_b <= 1'b0;
            oe_a <= 1'b0;
            oe_b <= 1'b0;
        end else begin
            out_a <= level[0];
            out_b <= level[1];
            oe_a <= next_oe[0];
            oe_b <= next_oe[1];
        end
    end

    // Event flags
    always_comb begin
        flag_set = '0;
        flag_set[FLG_OVF] = ev_ovf;
        flag_set[FLG_CAP] = ev_top && (mode == MODE_CAPTOP);
        flag_set[FLG_CMP_LSB +: NCH] = match;
        if (ev_top && (mode == MODE_CMPTOP)) begin
            flag_set[FLG_CMP_LSB] = 1'b1;
        end
    end

    // Register bus
    always_comb begin
        next_aw_held = aw_held;
        next_w_held = w_held;
        next_wr_addr = wr_addr;
        next_wr_data = wr_data;
        next_wr_strb = wr_strb;
        next_bvalid = bvalid;
        next_bresp = bresp;
        next_rvalid = rvalid;
        next_rdata = rdata;
        next_rresp = rresp;
        next_ctrl = ctrl;
        next_buf = buf_q;
        next_top_cap = top_cap;
        flag_clr = '0;
        if (awvalid && awready) begin
            next_aw_held = 1'b1;
            next_wr_addr = awaddr;
        end
        if (wvalid && wready) begin
            next_w_held = 1'b1;
            next_wr_data = wdata;
            next_wr_strb = wstrb;
        end
        if (bvalid && bready) begin
            next_bvalid = 1'b0;
        end
        if (aw_held && w_held && !bvalid) begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = RESP_OKAY;
            case (wr_addr)
                OFS_CTRL: next_ctrl = merge16(ctrl, wr_data, wr_strb);
                OFS_CMPA: next_buf[0] = merge16(buf_q[0], wr_data, wr_strb);
                OFS_CMPB: next_buf[1] = merge16(buf_q[1], wr_data, wr_strb);
                OFS_TOP: next_top_cap = merge16(top_cap, wr_data, wr_strb);
                OFS_FLAGS: begin
                    if (wr_strb[0]) begin
                        flag_clr = wr_data[FLG_W-1:0];
                    end
                end
                OFS_COUNT, OFS_STATUS: next_bresp = RESP_OKAY;
                default: next_bresp = RESP_SLVERR;
            endcase
        end
        // An event in the clearing cycle survives the clear
        next_flags = (flags & ~flag_clr) | flag_set;
        if (rvalid && rready) begin
            next_rvalid = 1'b0;
        end
        if (arvalid && arready) begin
            next_rvalid = 1'b1;
            next_rresp = RESP_OKAY;
            next_rdata = '0;
            case (araddr)
                OFS_CTRL: next_rdata[CTRL_W-1:0] = ctrl;
                OFS_COUNT: next_rdata[CNT_W-1:0] = cnt;
                OFS_CMPA: next_rdata[CNT_W-1:0] = buf_q[0];
                OFS_CMPB: next_rdata[CNT_W-1:0] = buf_q[1];
                OFS_TOP: next_rdata[CNT_W-1:0] = top_cap;
                OFS_FLAGS: next_rdata[FLG_W-1:0] = flags;
                OFS_STATUS: begin
                    next_rdata[STS_DOWN] = (dir == DIR_DOWN);
                    next_rdata[STS_LVL_LSB +: NCH] = level;
                end
                default: next_rresp = RESP_SLVERR;
            endcase
        end
        next_awready = !next_aw_held && !next_bvalid;
        next_wready = !next_w_held && !next_bvalid;
        next_arready = !next_rvalid;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            wr_addr <= '0;
            wr_data <= '0;
            wr_strb <= '0;
            awready <= 1'b0;
            wready <= 1'b0;
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
            arready <= 1'b0;
            rvalid <= 1'b0;
            rdata <= '0;
            rresp <= RESP_OKAY;
            ctrl <= CTRL_RST;
            buf_q <= '{default: CNT_BOTTOM};
            top_cap <= CNT_BOTTOM;
            flags <= '0;
        end else begin
            aw_held <= next_aw_held;
            w_held <= next_w_held;
            wr_addr <= next_wr_addr;
            wr_data <= next_wr_data;
            wr_strb <= next_wr_strb;
            awready <= next_awready;
            wready <= next_wready;
            bvalid <= next_bvalid;
            bresp <= next_bresp;
            arready <= next_arready;
            rvalid <= next_rvalid;
            rdata <= next_rdata;
            rresp <= next_rresp;
            ctrl <= next_ctrl;
            buf_q <= next_buf;
            top_cap <= next_top_cap;
            flags <= next_flags;
        end
    end
endmodule

// ==== dv/pfcpwm_checker.sv ====
`timescale 1ns/1ps
module pfcpwm_checker
    import pfcpwm_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Register bus
    input wire logic awvalid,
    input wire logic awready,
    input wire logic [pfcpwm_pkg::ADDR_W-1:0] awaddr,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic [pfcpwm_pkg::DATA_W-1:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic [1:0] bresp,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic [pfcpwm_pkg::ADDR_W-1:0] araddr,
    input wire logic rvalid,
    input wire logic rready,
    input wire logic [pfcpwm_pkg::DATA_W-1:0] rdata,
    input wire logic [1:0] rresp,
    // Compare pins
    input wire logic out_a,
    input wire logic oe_a,
    input wire logic out_b,
    input wire logic oe_b
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    logic [7:0] aw_q, ar_q;
    logic [15:0] wd_q, ctl;
    logic [1:0] ws_q;
    logic b_q;
    logic [2:0] stop_cnt;
    logic exp_oe_a, exp_oe_b;
    assign exp_oe_a = ctl[12] & ctl[14] & (ctl[9] | (ctl[8] & ctl[3]));
    assign exp_oe_b = ctl[13] & ctl[15] & ctl[11];

    // Shadow control word, committed as the write answer appears
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctl <= '0;
            b_q <= 1'b0;
            aw_q <= '0;
            ar_q <= '0;
            wd_q <= '0;
            ws_q <= '0;
            stop_cnt <= '0;
        end else begin
            b_q <= bvalid;
            if (awvalid && awready)
                aw_q <= awaddr;
            if (arvalid && arready)
                ar_q <= araddr;
            if (wvalid && wready) begin
                wd_q <= wdata[15:0];
                ws_q <= wstrb[1:0];
            end
            if (bvalid && !b_q && aw_q == OFS_CTRL) begin
                if (ws_q[0])
                    ctl[7:0] <= wd_q[7:0];
                if (ws_q[1])
                    ctl[15:8] <= wd_q[15:8];
            end
            // Margin covers a tick already in flight when stopped
            if (ctl[6:4] != 3'h0 && ctl[6:4] < 3'h6)
                stop_cnt <= '0;
            else if (stop_cnt != 3'h7)
                stop_cnt <= stop_cnt + 3'h1;
        end
    end

    // Both halves are held one cycle before the answer is raised
    a_b_after_hs: assert property (
        awvalid && awready && wvalid && wready |-> ##2 bvalid)
        else $error("write answer missing");
    a_r_after_ar: assert property (arvalid && arready |=> rvalid)
        else $error("read answer missing");
    a_b_holds: assert property (
        bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write answer dropped early");
    a_r_holds: assert property (
        rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
        else $error("read answer dropped early");
    a_ar_blocked: assert property (rvalid |-> !arready)
        else $error("read address open while answer pending");
    a_wr_resp_map: assert property ($rose(bvalid) && aw_q[1:0] == 2'h0
        |-> bresp == ((aw_q > OFS_STATUS) ? RESP_SLVERR : RESP_OKAY))
        else $error("write response code wrong");
    a_rd_err_zero: assert property ($rose(rvalid) && ar_q > OFS_STATUS
        |-> rresp == RESP_SLVERR && rdata == '0)
        else $error("unmapped read answered wrongly");
    a_oe_a_follow: assert property (oe_a == exp_oe_a)
        else $error("pin A drive enable wrong");
    a_oe_b_follow: assert property (oe_b == exp_oe_b)
        else $error("pin B drive enable wrong");
    a_idle_hold: assert property (
        stop_cnt == 3'h7 |-> $stable(out_a) && $stable(out_b))
        else $error("level moved without timer tick");

    c_write: cover property (bvalid && bready);
    c_read: cover property (rvalid && rready);
    c_pwm_edge: cover property (oe_a && $rose(out_a));
endmodule

// ==== dv/pfcpwm_pin_load.sv ====
`timescale 1ns/1ps
module pfcpwm_pin_load (
    // Block side
    input wire logic out_a,
    input wire logic oe_a,
    input wire logic out_b,
    input wire logic oe_b,
    // Pad level seen by the load
    output logic pin_a,
    output logic pin_b
);
    // Undriven pad sinks to the load's pull-down
    assign pin_a = oe_a ? out_a : 1'b0;
    assign pin_b = oe_b ? out_b : 1'b0;
endmodule

// ==== dv/pfcpwm_tb_top.sv ====
`timescale 1ns/1ps
module pfcpwm_tb_top;
    import pfcpwm_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
    logic [DATA_W-1:0] wdata = '0;
    logic [3:0] wstrb = '0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [DATA_W-1:0] rdata;
    logic out_a, oe_a, out_b, oe_b, pin_a, pin_b;
    int err_total = 0;
    int samples_checked = 0;
    // Capture TOP for fixed periods, compare A TOP otherwise
    int t_mode[6] = '{8, 8, 9, 9, 8, 8};
    int t_cs[6] = '{1, 2, 3, 4, 5, 1};
    int t_n[6] = '{1, 8, 64, 256, 1024, 1};
    int t_top[6] = '{5, 4, 3, 6, 3, 0};
    int t_ca[6] = '{2, 0, 0, 0, 1, 2};
    int t_cb[6] = '{-1, 4, -1, 3, 2, -1};
    int t_coma[6] = '{2, 3, 1, 2, 0, 3};
    int t_comb[6] = '{3, 2, 3, 1, 2, 2};
    int t_en[6] = '{15, 15, 15, 15, 13, 15};

    always #2.5 aclk = ~aclk;

    pfcpwm_top u_dut (
        .aclk, .aresetn, .awvalid, .awready, .awaddr, .awprot(3'h0),
        .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp,
        .arvalid, .arready, .araddr, .arprot(3'h0), .rvalid, .rready,
        .rdata, .rresp, .out_a, .oe_a, .out_b, .oe_b
    );
    pfcpwm_pin_load u_load (.out_a, .oe_a, .out_b, .oe_b, .pin_a, .pin_b);

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic final_report();
        $display("checks=%0d mismatches=%0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic tmo(input int n);
        if (n >= 50) begin
            err_total++;
            final_report();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er);
        int n;
        int dly;
        dly = $urandom % 5;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hf;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        // Late ready now and then makes the slave hold its answer
        bready <= (dly == 0);
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (awvalid && awready)
                awvalid <= 1'b0;
            if (wvalid && wready)
                wvalid <= 1'b0;
            if (bvalid === 1'b1 && bready === 1'b1)
                break;
            if (n + 1 >= dly)
                bready <= 1'b1;
        end
        bready <= 1'b0;
        tmo(n);
        check({30'h0, bresp}, {30'h0, er});
    endtask

    task automatic rd(input logic [7:0] a, input logic [1:0] er,
                      output logic [31:0] d);
        int n;
        int dly;
        dly = $urandom % 5;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= (dly == 0);
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (arvalid && arready)
                arvalid <= 1'b0;
            if (rvalid === 1'b1 && rready === 1'b1)
                break;
            if (n + 1 >= dly)
                rready <= 1'b1;
        end
        rready <= 1'b0;
        d = rdata;
        tmo(n);
        check({30'h0, rresp}, {30'h0, er});
    endtask

    // High cycles over two timer periods
    function automatic int exp_hi(int com, int c, int top, int n, bit is_a);
        if (com == 1)
            return is_a ? 2 * top * n : 0;
        if (com == 0)
            return 0;
        return (com == 2) ? 4 * c * n : 4 * (top - c) * n;
    endfunction

    initial begin
        int i, top, ca, cb, ctrl, n, ea, eb, ha, hb;
        logic [31:0] d, v;
        void'($urandom(32'h90db7d44));
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        for (i = 0; i < 7; i++) begin
            rd(8'(i * 4), RESP_OKAY, d);
            check(d, 32'h0);
        end
        rd(8'h1c, RESP_SLVERR, d);
        check(d, 32'h0);
        wr(8'h40, 32'hffff, RESP_SLVERR);
        v = $urandom;
        wr(OFS_CMPB, v, RESP_OKAY);
        rd(OFS_CMPB, RESP_OKAY, d);
        check(d, v & 32'hffff);
        wr(OFS_COUNT, v, RESP_OKAY);
        rd(OFS_COUNT, RESP_OKAY, d);
        check(d, 32'h0);
        $display("test registers done");
        for (i = 0; i < 6; i++) begin
            top = t_top[i];
            if (top == 0)
                top = 3 + $urandom % 4;
            ca = (t_mode[i] == 9) ? top : t_ca[i];
            cb = (t_cb[i] < 0) ? $urandom % (top + 1) : t_cb[i];
            n = t_n[i];
            ctrl = t_mode[i] | t_coma[i] << 8 | t_comb[i] << 10;
            ctrl = ctrl | t_en[i] << 12;
            wr(OFS_TOP, top, RESP_OKAY);
            wr(OFS_CMPA, ca, RESP_OKAY);
            wr(OFS_CMPB, cb, RESP_OKAY);
            wr(OFS_CTRL, ctrl | t_cs[i] << 4, RESP_OKAY);
            // Two periods let the buffered compares settle
            repeat (4 * top * n + n + 16) @(posedge aclk);
            ha = 0;
            hb = 0;
            repeat (4 * top * n) begin
                @(posedge aclk);
                ha += pin_a;
                hb += pin_b;
            end
            ea = (t_en[i] & 5) == 5 ? exp_hi(t_coma[i], ca, top, n, 1) : 0;
            eb = (t_en[i] & 10) == 10 ? exp_hi(t_comb[i], cb, top, n, 0) : 0;
            check(ha, ea);
            check(hb, eb);
            wr(OFS_CTRL, ctrl, RESP_OKAY);
            rd(OFS_CTRL, RESP_OKAY, d);
            check(d, ctrl);
            rd(OFS_COUNT, RESP_OKAY, d);
            check(32'(d <= top), 32'h1);
            rd(OFS_FLAGS, RESP_OKAY, d);
            check(d, t_mode[i] == 8 ? 32'hf : 32'hd);
            wr(OFS_FLAGS, 32'hf, RESP_OKAY);
            rd(OFS_FLAGS, RESP_OKAY, d);
            check(d, 32'h0);
            $display("test row %0d done", i);
        end
        final_report();
    end
endmodule

bind pfcpwm_top pfcpwm_checker u_chk (
    .aclk, .aresetn, .awvalid, .awready, .awaddr, .wvalid, .wready,
    .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready,
    .araddr, .rvalid, .rready, .rdata, .rresp, .out_a, .oe_a, .out_b,
    .oe_b
);
